// ---- include/stack_active_data_pointer_defs.svh ----
// Register offsets, reset values and field positions of the stack and pointer block
`ifndef STACK_ACTIVE_DATA_POINTER_DEFS_SVH
`define STACK_ACTIVE_DATA_POINTER_DEFS_SVH

`define SDP_ADDR_STACK      8'h81
`define SDP_ADDR_P0_LOW     8'h82
`define SDP_ADDR_P0_HIGH    8'h83
`define SDP_ADDR_P1_LOW     8'h84
`define SDP_ADDR_P1_HIGH    8'h85
`define SDP_ADDR_CHOICE     8'h86

`define SDP_STACK_RESET     8'h07
`define SDP_BYTE_ZERO       8'h00
`define SDP_POINTER_ZERO    16'h0000
`define SDP_POINTER_ONE     16'h0001
`define SDP_STACK_STEP      8'h01
`define SDP_CHOICE_SEL_BIT  0
`define SDP_CHOICE_PAD      7'h00

`endif

// ---- include/stack_active_data_pointer_pkg.sv ----
// Types and helpers shared by the stack and pointer block
package stack_active_data_pointer_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] pointer_t;

    typedef enum logic {
        PAIR_ZERO = 1'b0,
        PAIR_ONE  = 1'b1
    } pair_sel_e;

    // Active pointer as seen by pointer instructions
    function automatic pointer_t pick_pointer(input logic     sel,
                                              input pointer_t p0,
                                              input pointer_t p1);
        pick_pointer = (sel == PAIR_ONE) ? p1 : p0;
    endfunction : pick_pointer

endpackage : stack_active_data_pointer_pkg

// ---- hdl/pointer_pair.sv ----
// One 16-bit data pointer built from a low and a high byte register
`include "stack_active_data_pointer_defs.svh"

module pointer_pair (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_resetn,
    input  wire logic                      i_low_we,
    input  wire logic                      i_high_we,
    input  wire stack_active_data_pointer_pkg::byte_t     i_wdata,
    input  wire logic                      i_load,
    input  wire stack_active_data_pointer_pkg::pointer_t  i_load_value,
    input  wire logic                      i_inc,
    output stack_active_data_pointer_pkg::pointer_t       o_pointer,
    output stack_active_data_pointer_pkg::pointer_t       o_next_pointer
);

    stack_active_data_pointer_pkg::pointer_t pointer;
    stack_active_data_pointer_pkg::pointer_t next_pointer;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte stores win over whole-pointer updates; the core never issues both
    always_comb begin
        next_pointer = pointer;
        if (i_load) begin
            next_pointer = i_load_value;
        end else if (i_inc) begin
            next_pointer = pointer + `SDP_POINTER_ONE;
        end
        if (i_low_we) begin
            next_pointer[7:0] = i_wdata;
        end
        if (i_high_we) begin
            next_pointer[15:8] = i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pointer <= `SDP_POINTER_ZERO;
        end else begin
            pointer <= next_pointer;
        end
    end

    assign o_pointer      = pointer;
    assign o_next_pointer = next_pointer;

endmodule : pointer_pair

// ---- hdl/stack_and_dual_data_pointer.sv ----
// Stack pointer, two data pointers and pointer choice register of the core
`include "stack_active_data_pointer_defs.svh"

// What this block does
// RL1 - Stack index pre-increments on push, post-decrements on pop
// RL2 - Stack index resets to 07h
// RL3 - First pointer is low plus high byte
// RL4 - Auxiliary pointer has its own byte pair
// RL5 - Choice bit steers pointer instructions between pairs
// RL6 - Pointer bytes, choice reset zero; upper bits zero
module stack_and_dual_data_pointer (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_resetn,
    input  wire stack_active_data_pointer_pkg::byte_t     i_sfr_addr,
    input  wire logic                      i_sfr_wr,
    input  wire stack_active_data_pointer_pkg::byte_t     i_sfr_wdata,
    input  wire logic                      i_sfr_rd,
    input  wire logic                      i_stack_push,
    input  wire logic                      i_stack_pop,
    input  wire logic                      i_active_data_pointer_load,
    input  wire stack_active_data_pointer_pkg::pointer_t  i_active_data_pointer_value,
    input  wire logic                      i_active_data_pointer_inc,
    output stack_active_data_pointer_pkg::byte_t          o_sfr_rdata,
    output logic                           o_sfr_hit,
    output stack_active_data_pointer_pkg::byte_t          o_stack_top_index,
    output stack_active_data_pointer_pkg::pointer_t       o_active_data_pointer,
    output logic                           o_pointer_choice
);

    stack_active_data_pointer_pkg::byte_t    stack_top_index;
    stack_active_data_pointer_pkg::byte_t    next_stack_top_index;
    logic                     choice;
    logic                     next_choice;
    stack_active_data_pointer_pkg::pointer_t active_data_pointer;
    stack_active_data_pointer_pkg::pointer_t next_active_data_pointer;
    stack_active_data_pointer_pkg::byte_t    rdata;
    stack_active_data_pointer_pkg::byte_t    next_rdata;
    logic                     hit;
    logic                     next_hit;
    stack_active_data_pointer_pkg::pointer_t pointer0;
    stack_active_data_pointer_pkg::pointer_t pointer1;
    stack_active_data_pointer_pkg::pointer_t next_pointer0;
    stack_active_data_pointer_pkg::pointer_t next_pointer1;
    logic                     wr_stack;
    logic                     wr_p0_low;
    logic                     wr_p0_high;
    logic                     wr_p1_low;
    logic                     wr_p1_high;
    logic                     wr_choice;
    logic                     use_pair1;

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode
    assign wr_stack   = i_sfr_wr && (i_sfr_addr == `SDP_ADDR_STACK);
    assign wr_p0_low  = i_sfr_wr && (i_sfr_addr == `SDP_ADDR_P0_LOW);
    assign wr_p0_high = i_sfr_wr && (i_sfr_addr == `SDP_ADDR_P0_HIGH);
    assign wr_p1_low  = i_sfr_wr && (i_sfr_addr == `SDP_ADDR_P1_LOW);
    assign wr_p1_high = i_sfr_wr && (i_sfr_addr == `SDP_ADDR_P1_HIGH);
    assign wr_choice  = i_sfr_wr && (i_sfr_addr == `SDP_ADDR_CHOICE);
    // Steering uses the choice already stored, not one written this cycle
    assign use_pair1  = (choice == stack_active_data_pointer_pkg::PAIR_ONE); // RL5

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer pairs
    pointer_pair u_pair0 (
        .i_sys_clk      (i_sys_clk),
        .i_resetn       (i_resetn),
        .i_low_we       (wr_p0_low),
        .i_high_we      (wr_p0_high),
        .i_wdata        (i_sfr_wdata),
        .i_load         (i_active_data_pointer_load && !use_pair1),
        .i_load_value   (i_active_data_pointer_value),
        .i_inc          (i_active_data_pointer_inc && !use_pair1),
        .o_pointer      (pointer0),
        .o_next_pointer (next_pointer0)
    ); // RL3

    pointer_pair u_pair1 (
        .i_sys_clk      (i_sys_clk),
        .i_resetn       (i_resetn),
        .i_low_we       (wr_p1_low),
        .i_high_we      (wr_p1_high),
        .i_wdata        (i_sfr_wdata),
        .i_load         (i_active_data_pointer_load && use_pair1),
        .i_load_value   (i_active_data_pointer_value),
        .i_inc          (i_active_data_pointer_inc && use_pair1),
        .o_pointer      (pointer1),
        .o_next_pointer (next_pointer1)
    ); // RL4

    ////////////////////////////////////////////////////////////////////////////////
    // Stack index and choice bit
    always_comb begin
        next_stack_top_index = stack_top_index;
        next_choice          = choice;
        // Push and pop together cancel out
        if (i_stack_push && !i_stack_pop) begin
            next_stack_top_index = stack_top_index + `SDP_STACK_STEP; // RL1
        end else if (i_stack_pop && !i_stack_push) begin
            next_stack_top_index = stack_top_index - `SDP_STACK_STEP; // RL1
        end
        // Software store wins over a same-cycle push or pop
        if (wr_stack) begin
            next_stack_top_index = i_sfr_wdata;
        end
        if (wr_choice) begin
            next_choice = i_sfr_wdata[`SDP_CHOICE_SEL_BIT];
        end
        next_active_data_pointer = stack_active_data_pointer_pkg::pick_pointer(next_choice, next_pointer0,
                                                                next_pointer1); // RL5
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path, one cycle after the strobe
    always_comb begin
        next_rdata = `SDP_BYTE_ZERO;
        next_hit   = 1'b0;
        if (i_sfr_rd) begin
            next_hit = 1'b1;
            case (i_sfr_addr)
                `SDP_ADDR_STACK:   next_rdata = stack_top_index;
                `SDP_ADDR_P0_LOW:  next_rdata = pointer0[7:0];
                `SDP_ADDR_P0_HIGH: next_rdata = pointer0[15:8];
                `SDP_ADDR_P1_LOW:  next_rdata = pointer1[7:0];
                `SDP_ADDR_P1_HIGH: next_rdata = pointer1[15:8];
                `SDP_ADDR_CHOICE:  next_rdata = {`SDP_CHOICE_PAD, choice}; // RL6
                default: begin
                    next_rdata = `SDP_BYTE_ZERO;
                    next_hit   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stack_top_index     <= `SDP_STACK_RESET; // RL2
            choice              <= 1'b0; // RL6
            active_data_pointer <= `SDP_POINTER_ZERO; // RL6
            rdata               <= `SDP_BYTE_ZERO;
            hit                 <= 1'b0;
        end else begin
            stack_top_index     <= next_stack_top_index;
            choice              <= next_choice;
            active_data_pointer <= next_active_data_pointer;
            rdata               <= next_rdata;
            hit                 <= next_hit;
        end
    end

    assign o_sfr_rdata           = rdata;
    assign o_sfr_hit             = hit;
    assign o_stack_top_index     = stack_top_index;
    assign o_active_data_pointer = active_data_pointer;
    assign o_pointer_choice      = choice;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    // Low until the first edge after reset release
    logic seen_edge;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            seen_edge <= 1'b0;
        end else begin
            seen_edge <= 1'b1;
        end
    end

    property p_push_increments;
        i_stack_push && !i_stack_pop && !wr_stack
            |=> stack_top_index == $past(stack_top_index) + `SDP_STACK_STEP;
    endproperty
    a_push_increments: assert property (p_push_increments) // RL1
        else $error("stack index did not rise by one on push");

    property p_pop_decrements;
        i_stack_pop && !i_stack_push && !wr_stack
            |=> stack_top_index == $past(stack_top_index) - `SDP_STACK_STEP;
    endproperty
    a_pop_decrements: assert property (p_pop_decrements) // RL1
        else $error("stack index did not fall by one on pop");

    property p_stack_reset;
        !seen_edge |-> stack_top_index == `SDP_STACK_RESET;
    endproperty
    a_stack_reset: assert property (p_stack_reset) // RL2
        else $error("stack index not at reset value after reset");

    property p_pair0_low_store;
        wr_p0_low ##1 !wr_p0_low && !i_active_data_pointer_load && !i_active_data_pointer_inc
            |=> pointer0[7:0] == $past(i_sfr_wdata, 2);
    endproperty
    a_pair0_low_store: assert property (p_pair0_low_store) // RL3
        else $error("first pointer low byte lost its store");

    property p_pair1_high_store;
        wr_p1_high |=> pointer1[15:8] == $past(i_sfr_wdata) && $stable(choice);
    endproperty
    a_pair1_high_store: assert property (p_pair1_high_store) // RL4
        else $error("auxiliary pointer high byte lost its store");

    property p_active_follows_choice;
        o_active_data_pointer == (choice ? pointer1 : pointer0);
    endproperty
    a_active_follows_choice: assert property (p_active_follows_choice) // RL5
        else $error("active pointer does not match choice bit");

    property p_inc_steered;
        i_active_data_pointer_inc && !i_active_data_pointer_load && !i_sfr_wr && use_pair1
            |=> pointer1 == $past(pointer1) + `SDP_POINTER_ONE && $stable(pointer0);
    endproperty
    a_inc_steered: assert property (p_inc_steered) // RL5
        else $error("pointer increment not steered to auxiliary pair");

    property p_choice_reads_narrow;
        i_sfr_rd && i_sfr_addr == `SDP_ADDR_CHOICE
            |=> o_sfr_rdata[7:1] == `SDP_CHOICE_PAD && o_sfr_hit;
    endproperty
    a_choice_reads_narrow: assert property (p_choice_reads_narrow) // RL6
        else $error("choice register upper bits not zero");

    property p_pointers_reset;
        !seen_edge |-> pointer0 == `SDP_POINTER_ZERO && pointer1 == `SDP_POINTER_ZERO
                       && !choice;
    endproperty
    a_pointers_reset: assert property (p_pointers_reset) // RL6
        else $error("pointers or choice not zero after reset");

    c_push_then_pop: cover property (i_stack_push ##1 i_stack_pop);
    c_pair1_inc: cover property (i_active_data_pointer_inc && use_pair1);
    c_choice_set: cover property (wr_choice && i_sfr_wdata[`SDP_CHOICE_SEL_BIT]);
    c_load_pair0: cover property (i_active_data_pointer_load && !use_pair1);

endmodule : stack_and_dual_data_pointer

// ---- sim/core_model.sv ----
// Stand-in for the core's instruction execution logic
module core_model (
    input  wire logic                 i_sys_clk,
    output logic                      o_stack_push,
    output logic                      o_stack_pop,
    output logic                      o_active_data_pointer_load,
    output stack_active_data_pointer_pkg::pointer_t  o_active_data_pointer_value,
    output logic                      o_active_data_pointer_inc
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_stack_push = 1'b0;
        o_stack_pop = 1'b0;
        o_active_data_pointer_load = 1'b0;
        o_active_data_pointer_inc = 1'b0;
        o_active_data_pointer_value = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle operation pulse
    // Value line inverted afterwards so a stale value cannot pass for a fresh one
    task automatic issue(input logic push, input logic pop, input logic load,
                         input logic inc, input stack_active_data_pointer_pkg::pointer_t value);
        @(posedge i_sys_clk);
        o_stack_push <= push;
        o_stack_pop <= pop;
        o_active_data_pointer_load <= load;
        o_active_data_pointer_inc <= inc;
        o_active_data_pointer_value <= value;
        @(posedge i_sys_clk);
        o_stack_push <= 1'b0;
        o_stack_pop <= 1'b0;
        o_active_data_pointer_load <= 1'b0;
        o_active_data_pointer_inc <= 1'b0;
        o_active_data_pointer_value <= ~value;
        #1;
    endtask : issue
endmodule : core_model

// ---- sim/testbench.sv ----
// Self-checking bench for the stack and dual pointer block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      i_sys_clk;
    logic                      i_resetn;
    stack_active_data_pointer_pkg::byte_t     sfr_addr;
    stack_active_data_pointer_pkg::byte_t     sfr_wdata;
    stack_active_data_pointer_pkg::byte_t     sfr_rdata;
    stack_active_data_pointer_pkg::byte_t     stack_idx;
    logic                      sfr_wr;
    logic                      sfr_rd;
    logic                      sfr_hit;
    logic                      push;
    logic                      pop;
    logic                      load;
    logic                      inc;
    logic                      choice;
    stack_active_data_pointer_pkg::pointer_t  value;
    stack_active_data_pointer_pkg::pointer_t  active;
    int                        n_errors = 0;
    int                        n_checks = 0;

    stack_and_dual_data_pointer dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_sfr_addr(sfr_addr),
        .i_sfr_wr(sfr_wr), .i_sfr_wdata(sfr_wdata), .i_sfr_rd(sfr_rd),
        .i_stack_push(push), .i_stack_pop(pop), .i_active_data_pointer_load(load),
        .i_active_data_pointer_value(value), .i_active_data_pointer_inc(inc), .o_sfr_rdata(sfr_rdata),
        .o_sfr_hit(sfr_hit), .o_stack_top_index(stack_idx),
        .o_active_data_pointer(active), .o_pointer_choice(choice));

    core_model core (
        .i_sys_clk(i_sys_clk), .o_stack_push(push), .o_stack_pop(pop),
        .o_active_data_pointer_load(load), .o_active_data_pointer_value(value), .o_active_data_pointer_inc(inc));

    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_sys_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= addr;
        sfr_wdata <= data;
        @(posedge i_sys_clk);
        sfr_wr <= 1'b0;
        sfr_wdata <= ~data;
        #1;
    endtask : write_reg

    // Answer stands one cycle only, so it is sampled just after the strobe edge
    task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp, input logic hit);
        @(posedge i_sys_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= addr;
        @(posedge i_sys_clk);
        sfr_rd <= 1'b0;
        #1;
        check("read data", {8'h00, exp}, {8'h00, sfr_rdata});
        check("read hit", {15'h0000, hit}, {15'h0000, sfr_hit});
    endtask : read_reg

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4000) @(posedge i_sys_clk);
        n_errors++;
        $display("unexpected run length: expected below 4000 cycles, seen 4000");
        conclude();
    end

    initial begin
        i_resetn = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        repeat (20) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        read_reg(8'h81, 8'h07, 1'b1);
        for (int a = 8'h82; a <= 8'h86; a++) begin
            read_reg(8'(a), 8'h00, 1'b1);
        end
        read_reg(8'h87, 8'h00, 1'b0);
        check("active pointer", 16'h0000, active);
        $display("test reset_values done");

        core.issue(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        core.issue(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        check("stack index", 16'h0009, {8'h00, stack_idx});
        core.issue(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
        read_reg(8'h81, 8'h08, 1'b1);
        write_reg(8'h81, 8'hFF);
        core.issue(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        check("stack index", 16'h0000, {8'h00, stack_idx});
        core.issue(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
        check("stack index", 16'h00FF, {8'h00, stack_idx});
        // Push and pop in one cycle leave the index alone
        core.issue(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
        check("stack index", 16'h00FF, {8'h00, stack_idx});
        $display("test stack done");

        write_reg(8'h82, 8'h34);
        write_reg(8'h83, 8'h12);
        write_reg(8'h84, 8'hCD);
        write_reg(8'h85, 8'hAB);
        check("active pointer", 16'h1234, active);
        write_reg(8'h86, 8'hFF);
        check("choice", 16'h0001, {15'h0000, choice});
        check("active pointer", 16'hABCD, active);
        read_reg(8'h86, 8'h01, 1'b1);
        core.issue(1'b0, 1'b0, 1'b1, 1'b0, 16'h5678);
        read_reg(8'h84, 8'h78, 1'b1);
        read_reg(8'h85, 8'h56, 1'b1);
        core.issue(1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
        check("active pointer", 16'h5679, active);
        write_reg(8'h86, 8'h00);
        check("active pointer", 16'h1234, active);
        core.issue(1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
        read_reg(8'h82, 8'h35, 1'b1);
        read_reg(8'h84, 8'h79, 1'b1);
        // Load beats increment and must stay on the first pair
        core.issue(1'b0, 1'b0, 1'b1, 1'b1, 16'h9ABC);
        check("active pointer", 16'h9ABC, active);
        read_reg(8'h83, 8'h9A, 1'b1);
        read_reg(8'h85, 8'h56, 1'b1);
        $display("test pointers done");

        @(posedge i_sys_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        read_reg(8'h81, 8'h07, 1'b1);
        read_reg(8'h85, 8'h00, 1'b1);
        check("active pointer", 16'h0000, active);
        $display("test mid_reset done");
        conclude();
    end
endmodule : testbench
